//--- logic/pcsd_chan.sv
/*
  Address comparator of one programmable select channel.
  Assumes the cycle description is already synchronised to core_clk_i.
*/
`timescale 1ns/1ns
module pcsd_chan (
  // Channel settings and the current cycle.
  input  wire pcsd_pkg::pcsd_chan_cfg_s cfg_i,
  input  wire pcsd_pkg::pcsd_cycle_s    cyc_i,
  // Combinational select request, active high.
  output logic                          hit_o
);

  logic [9:0] want;
  logic [9:0] got;
  logic [9:0] care;
  logic       kind_ok;
  logic       dir_ok;
  logic       time_ok;

  // ==========================================================================
  // Compare ten bits; memory mode uses A23..A14, I/O mode A9..A0.
  always_comb begin
    want = {cfg_i.ctrl[pcsd_pkg::CTRL_UPPER_BIT], cfg_i.base, cfg_i.low_base}; // RQ1 RQ2 RQ3
    got  = cfg_i.rom_target ? cyc_i.addr[23:14] : cyc_i.addr[9:0]; // RQ9 RQ10 RQ14
    care = 10'h3ff;
    care[0] = ~cfg_i.low_mask; // RQ4
    care[4:1] = ~cfg_i.ctrl[pcsd_pkg::CTRL_MASK_HI:0]; // RQ5
    kind_ok = cfg_i.rom_target ? cyc_i.is_mem : cyc_i.is_io;
    dir_ok  = (cyc_i.is_wr & cfg_i.ctrl[pcsd_pkg::CTRL_WR_EN_BIT]) // RQ6
            | (cyc_i.is_rd & cfg_i.ctrl[pcsd_pkg::CTRL_RD_EN_BIT]); // RQ7
    // Early mode opens at the latch strobe, the other waits for the command.
    time_ok = cfg_i.ctrl[pcsd_pkg::CTRL_EARLY_BIT] ? (cyc_i.ale | cyc_i.cmd) : cyc_i.cmd; // RQ8
    hit_o = (((want ^ got) & care) == 10'h000) & kind_ok & dir_ok & time_ok; // RQ16
  end

endmodule

//--- logic/pcsd_pkg.sv
/*
  Shared constants and carrier types of the programmable chip select decoder:
  configuration space indices, field positions, reset values and timing.
  Assumes that every user refers to these names through pcsd_pkg::.
*/
package pcsd_pkg;

  // ==========================================================================
  // Index and data port addresses of the configuration space.
  localparam logic [15:0] IDX_PORT_ADDR = 16'h0022;
  localparam logic [15:0] DAT_PORT_ADDR = 16'h0024;

  // ==========================================================================
  // Register indices within the configuration space.
  localparam logic [7:0] IDX_ONE_BASE = 8'h4c;
  localparam logic [7:0] IDX_ONE_CTRL = 8'h4d;
  localparam logic [7:0] IDX_CYC_TYPE = 8'hb3;
  localparam logic [7:0] IDX_TWO_BASE = 8'hba;
  localparam logic [7:0] IDX_TWO_CTRL = 8'hbb;
  localparam logic [7:0] IDX_GRAN     = 8'hbf;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_BASE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CYC  = 8'h00;
  localparam logic [7:0] RST_GRAN = 8'h0f;

  // ==========================================================================
  // Control register field positions.
  localparam int CTRL_UPPER_BIT = 7;
  localparam int CTRL_WR_EN_BIT = 6;
  localparam int CTRL_RD_EN_BIT = 5;
  localparam int CTRL_EARLY_BIT = 4;
  localparam int CTRL_MASK_HI   = 3;

  // Granularity and cycle type field positions, per channel.
  localparam int GRAN_ONE_LOW_BIT  = 5;
  localparam int GRAN_TWO_LOW_BIT  = 6;
  localparam int GRAN_ONE_MASK_BIT = 1;
  localparam int GRAN_TWO_MASK_BIT = 2;
  localparam int CYC_ONE_ROM_BIT   = 1;
  localparam int CYC_TWO_ROM_BIT   = 2;
  localparam int CYC_ONE_WIDE_BIT  = 5;
  localparam int CYC_TWO_WIDE_BIT  = 6;

  // ==========================================================================
  // Timing: pin input synchroniser depth.
  localparam int SYNC_STAGES = 3;

  // Settings of one channel, gathered for the channel comparator.
  typedef struct packed {
    logic [7:0] base;
    logic [7:0] ctrl;
    logic       low_base;
    logic       low_mask;
    logic       rom_target;
  } pcsd_chan_cfg_s;

  // One bus cycle as seen by the comparators.
  typedef struct packed {
    logic [23:0] addr;
    logic        is_mem;
    logic        is_io;
    logic        is_rd;
    logic        is_wr;
    logic        ale;
    logic        cmd;
  } pcsd_cycle_s;

endpackage

//--- logic/pcsd_sync.sv
/*
  Three-stage pin synchroniser for a vector of inputs with agreement check.
  Assumes inputs are asynchronous to core_clk_i; output changes only when
  the second and third stage agree.
*/
`timescale 1ns/1ns
module pcsd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  // Raw and filtered levels.
  input  wire logic [WIDTH-1:0] raw_i,
  output logic      [WIDTH-1:0] level_o
);

  // ==========================================================================
  // Stage registers and the filtered level.
  logic [WIDTH-1:0] st1_r;
  logic [WIDTH-1:0] st2_r;
  logic [WIDTH-1:0] st3_r;
  logic [WIDTH-1:0] lvl_r;
  logic [WIDTH-1:0] st1_nxt;
  logic [WIDTH-1:0] st2_nxt;
  logic [WIDTH-1:0] st3_nxt;
  logic [WIDTH-1:0] lvl_nxt;
  logic [WIDTH-1:0] agree;

  // Shift the pins along; only the second stage reads the first, which may go metastable.
  always_comb begin
    st1_nxt = raw_i;
    st2_nxt = st1_r;
    st3_nxt = st2_r;
    agree   = st2_r ~^ st3_r;
    // A bit moves only once the second and third stages agree on it.
    lvl_nxt = (lvl_r & ~agree) | (st3_r & agree);
  end

  // Reset loads the present pin level so that no stage later looks like a pin change.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st1_r <= raw_i;
      st2_r <= raw_i;
      st3_r <= raw_i;
      lvl_r <= raw_i;
    end else begin
      st1_r <= st1_nxt;
      st2_r <= st2_nxt;
      st3_r <= st3_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;

endmodule

//--- logic/pcsd_top.sv
/*
  Programmable chip select decoder, channels one and two, with the indexed
  configuration space ports. Assumes ISA bus pins arrive asynchronously and
  pass the pin synchroniser; external gates combine the strobe and pins.
*/
`timescale 1ns/1ns
// Overview of operation
// [RQ1] Each channel holds an eight-bit base for I/O A8..A1 or memory A22..A15.
// [RQ2] Control bit 7 provides A9 in I/O mode or A23 in memory mode.
// [RQ3] Granularity bits 5 and 6 provide A0 or A14 for channels one, two.
// [RQ4] Granularity bits 1 and 2 mask the lowest compared bit per channel.
// [RQ5] Control bits 3..0 mask base bits of A4..A1 or A18..A15.
// [RQ6] Control bit 6 enables write decoding; clear blocks writes.
// [RQ7] Control bit 5 enables read decoding; clear blocks reads.
// [RQ8] Control bit 4 selects assertion with command or before latch strobe.
// [RQ9] Cycle type bit 1 picks I/O or ROM target for channel one.
// [RQ10] Cycle type bit 2 picks I/O or ROM target for channel two.
// [RQ11] Cycle type bit 5 gives channel one ROM width, eight or sixteen.
// [RQ12] Cycle type bit 6 gives channel two ROM width, eight or sixteen.
// [RQ13] Outside gates OR the qualified strobe with address pins nine and six.
// [RQ14] I/O decode compares ten bits; A15..A10 zero or ignored per control.
// [RQ15] Software writes index at 022h then data at 024h, every access.
// [RQ16] Select asserts only on full unmasked match, kind and direction enabled.
module pcsd_top (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // ISA side cycle pins.
  input  wire logic [23:0] sa_i,
  input  wire logic        ior_n_i,
  input  wire logic        iow_n_i,
  input  wire logic        memr_n_i,
  input  wire logic        memw_n_i,
  input  wire logic        ale_i,
  input  wire logic        aen_i,
  // Upper I/O bits must be zero when high, ignored when low.
  input  wire logic        io_upper_zero_i,
  // Data bus, three signals for the two-way pins.
  input  wire logic [7:0]  sd_i,
  output logic      [7:0]  sd_o,
  output logic             sd_oe_o,
  // Decode outputs.
  output logic             expansion_cycle_strobe_n_o,
  output logic             mem_addr_pin_nine_o,
  output logic             mem_addr_pin_six_o,
  output logic             rom_wide_one_o,
  output logic             rom_wide_two_o
);

  // Width of the bundle of pins that passes the synchroniser.
  localparam int PIN_W = 39;

  // ==========================================================================
  // Pin synchroniser.
  // All ISA pins, the data bus included, pass the same three stages, so a
  // command strobe never runs ahead of the address and data that it qualifies.
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_lvl;

  // Pack every asynchronous pin into one bundle.
  assign pins_raw = {sd_i, io_upper_zero_i, aen_i, ale_i, memw_n_i, memr_n_i, iow_n_i, ior_n_i, sa_i};

  pcsd_sync #(
    .WIDTH      (PIN_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .raw_i      (pins_raw),
    .level_o    (pins_lvl)
  );

  // Filtered pin levels, by name.
  logic [23:0] addr_lvl;
  logic        ior_n_lvl;
  logic        iow_n_lvl;
  logic        memr_n_lvl;
  logic        memw_n_lvl;
  logic        ale_lvl;
  logic        aen_lvl;
  logic        upper_zero_lvl;
  logic [7:0]  data_lvl;

  // Unpack the bundle in the order in which it was packed.
  assign addr_lvl       = pins_lvl[23:0];
  assign ior_n_lvl      = pins_lvl[24];
  assign iow_n_lvl      = pins_lvl[25];
  assign memr_n_lvl     = pins_lvl[26];
  assign memw_n_lvl     = pins_lvl[27];
  assign ale_lvl        = pins_lvl[28];
  assign aen_lvl        = pins_lvl[29];
  assign upper_zero_lvl = pins_lvl[30];
  assign data_lvl       = pins_lvl[38:31];

  // ==========================================================================
  // Cycle description seen by both comparators.
  pcsd_pkg::pcsd_cycle_s cyc;

  // Reads and writes of both spaces are folded into kind and direction.
  always_comb begin
    cyc.addr   = addr_lvl;
    cyc.is_io  = ~ior_n_lvl | ~iow_n_lvl;
    cyc.is_mem = ~memr_n_lvl | ~memw_n_lvl;
    cyc.is_rd  = ~ior_n_lvl | ~memr_n_lvl;
    cyc.is_wr  = ~iow_n_lvl | ~memw_n_lvl;
    cyc.ale    = ale_lvl;
    cyc.cmd    = ~(ior_n_lvl & iow_n_lvl & memr_n_lvl & memw_n_lvl);
  end

  // ==========================================================================
  // Command edge detection for the configuration ports.
  logic prev_ior_n_r;
  logic prev_iow_n_r;
  logic prev_ior_n_nxt;
  logic prev_iow_n_nxt;
  logic rd_start;
  logic wr_start;

  // The history follows the filtered level every cycle.
  always_comb begin
    prev_ior_n_nxt = ior_n_lvl;
    prev_iow_n_nxt = iow_n_lvl;
  end

  // Reset to the idle high level so that leaving reset never looks like a command.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prev_ior_n_r <= 1'b1;
      prev_iow_n_r <= 1'b1;
    end else begin
      prev_ior_n_r <= prev_ior_n_nxt;
      prev_iow_n_r <= prev_iow_n_nxt;
    end
  end

  // A command starts on the first cycle its filtered strobe is seen low.
  assign rd_start = prev_ior_n_r & ~ior_n_lvl;
  assign wr_start = prev_iow_n_r & ~iow_n_lvl;

  // ==========================================================================
  // Index and data ports of the configuration space.
  logic idx_port;
  logic dat_port;

  // DMA cycles (aen high) carry a DMA address, never a port access.
  assign idx_port = (addr_lvl[15:0] == pcsd_pkg::IDX_PORT_ADDR) & ~aen_lvl;
  assign dat_port = (addr_lvl[15:0] == pcsd_pkg::DAT_PORT_ADDR) & ~aen_lvl;

  // ==========================================================================
  // Register file and port state.
  logic [7:0] one_base_r;
  logic [7:0] one_ctrl_r;
  logic [7:0] cyc_type_r;
  logic [7:0] two_base_r;
  logic [7:0] two_ctrl_r;
  logic [7:0] gran_r;
  logic [7:0] idx_r;
  logic       idx_valid_r;
  logic [7:0] rd_data_r;
  logic       sd_oe_r;
  logic [7:0] one_base_nxt;
  logic [7:0] one_ctrl_nxt;
  logic [7:0] cyc_type_nxt;
  logic [7:0] two_base_nxt;
  logic [7:0] two_ctrl_nxt;
  logic [7:0] gran_nxt;
  logic [7:0] idx_nxt;
  logic       idx_valid_nxt;
  logic [7:0] rd_data_nxt;
  logic       sd_oe_nxt;
  logic [7:0] rd_mux;
  logic       rd_known;

  // Read multiplexer; indices owned by other blocks leave the data bus alone.
  always_comb begin
    rd_mux   = 8'h00;
    rd_known = 1'b1;
    case (idx_r)
      pcsd_pkg::IDX_ONE_BASE: rd_mux = one_base_r;
      pcsd_pkg::IDX_ONE_CTRL: rd_mux = one_ctrl_r;
      pcsd_pkg::IDX_CYC_TYPE: rd_mux = cyc_type_r;
      pcsd_pkg::IDX_TWO_BASE: rd_mux = two_base_r;
      pcsd_pkg::IDX_TWO_CTRL: rd_mux = two_ctrl_r;
      pcsd_pkg::IDX_GRAN:     rd_mux = gran_r;
      default:                rd_known = 1'b0;
    endcase
  end

  // Next values of the registers, the index and the read data.
  always_comb begin
    one_base_nxt  = one_base_r;
    one_ctrl_nxt  = one_ctrl_r;
    cyc_type_nxt  = cyc_type_r;
    two_base_nxt  = two_base_r;
    two_ctrl_nxt  = two_ctrl_r;
    gran_nxt      = gran_r;
    idx_nxt       = idx_r;
    idx_valid_nxt = idx_valid_r;
    rd_data_nxt   = rd_data_r;
    // The data bus is driven only while the read command stays low.
    sd_oe_nxt     = sd_oe_r & ~ior_n_lvl;
    if (wr_start && idx_port) begin
      idx_nxt       = data_lvl;
      idx_valid_nxt = 1'b1;
    end
    // Any data port access consumes the index, so each access needs a fresh index write.
    if ((wr_start || rd_start) && dat_port) begin
      idx_valid_nxt = 1'b0;
    end
    if (wr_start && dat_port && idx_valid_r) begin
      case (idx_r)
        pcsd_pkg::IDX_ONE_BASE: one_base_nxt = data_lvl; // RQ1
        pcsd_pkg::IDX_ONE_CTRL: one_ctrl_nxt = data_lvl; // RQ2 RQ5 RQ6 RQ7 RQ8
        pcsd_pkg::IDX_CYC_TYPE: cyc_type_nxt = data_lvl; // RQ9 RQ10 RQ11 RQ12
        pcsd_pkg::IDX_TWO_BASE: two_base_nxt = data_lvl; // RQ1
        pcsd_pkg::IDX_TWO_CTRL: two_ctrl_nxt = data_lvl; // RQ2 RQ5 RQ6 RQ7 RQ8
        pcsd_pkg::IDX_GRAN:     gran_nxt     = data_lvl; // RQ3 RQ4
        default:                idx_nxt      = idx_r;
      endcase
    end
    if (rd_start && dat_port && idx_valid_r && rd_known) begin
      rd_data_nxt = rd_mux;
      sd_oe_nxt   = 1'b1;
    end
  end

  // Register the configuration state.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      one_base_r  <= pcsd_pkg::RST_BASE;
      one_ctrl_r  <= pcsd_pkg::RST_CTRL;
      cyc_type_r  <= pcsd_pkg::RST_CYC;
      two_base_r  <= pcsd_pkg::RST_BASE;
      two_ctrl_r  <= pcsd_pkg::RST_CTRL;
      gran_r      <= pcsd_pkg::RST_GRAN;
      idx_r       <= 8'h00;
      idx_valid_r <= 1'b0;
      rd_data_r   <= 8'h00;
      sd_oe_r     <= 1'b0;
    end else begin
      one_base_r  <= one_base_nxt;
      one_ctrl_r  <= one_ctrl_nxt;
      cyc_type_r  <= cyc_type_nxt;
      two_base_r  <= two_base_nxt;
      two_ctrl_r  <= two_ctrl_nxt;
      gran_r      <= gran_nxt;
      idx_r       <= idx_nxt;
      idx_valid_r <= idx_valid_nxt;
      rd_data_r   <= rd_data_nxt;
      sd_oe_r     <= sd_oe_nxt;
    end
  end

  // ==========================================================================
  // Channel comparators, one per programmable select.
  logic [1:0] chan_sel;

  for (genvar gi = 0; gi < 2; gi++) begin : g_chan
    pcsd_pkg::pcsd_chan_cfg_s cfg;
    logic                     hit;
    logic                     upper_ok;

    // Gather the settings of this channel from the shared registers.
    always_comb begin
      cfg.base       = (gi == 0) ? one_base_r : two_base_r; // RQ1
      cfg.ctrl       = (gi == 0) ? one_ctrl_r : two_ctrl_r; // RQ2 RQ5 RQ6 RQ7 RQ8
      cfg.low_base   = gran_r[(gi == 0) ? pcsd_pkg::GRAN_ONE_LOW_BIT : pcsd_pkg::GRAN_TWO_LOW_BIT]; // RQ3
      cfg.low_mask   = gran_r[(gi == 0) ? pcsd_pkg::GRAN_ONE_MASK_BIT : pcsd_pkg::GRAN_TWO_MASK_BIT]; // RQ4
      cfg.rom_target = cyc_type_r[(gi == 0) ? pcsd_pkg::CYC_ONE_ROM_BIT : pcsd_pkg::CYC_TWO_ROM_BIT]; // RQ9 RQ10
      // I/O decodes ten bits only; the upper bits are checked here, not in the comparator.
      upper_ok       = cfg.rom_target | ~upper_zero_lvl | (addr_lvl[15:10] == 6'h00); // RQ14
    end

    pcsd_chan u_chan (
      .cfg_i (cfg),
      .cyc_i (cyc),
      .hit_o (hit)
    );

    // The comparator result is final only with the upper I/O bits accepted.
    assign chan_sel[gi] = hit & upper_ok; // RQ16
  end

  // ==========================================================================
  // Decode outputs.
  logic strobe_n_r;
  logic pin_nine_r;
  logic pin_six_r;
  logic wide_one_r;
  logic wide_two_r;
  logic strobe_n_nxt;
  logic pin_nine_nxt;
  logic pin_six_nxt;
  logic wide_one_nxt;
  logic wide_two_nxt;

  // The strobe marks any select; the address pins say which one it is.
  always_comb begin
    strobe_n_nxt = ~(chan_sel[0] | chan_sel[1]);
    pin_nine_nxt = ~chan_sel[0];
    pin_six_nxt  = ~chan_sel[1];
    wide_one_nxt = cyc_type_r[pcsd_pkg::CYC_ONE_WIDE_BIT]; // RQ11
    wide_two_nxt = cyc_type_r[pcsd_pkg::CYC_TWO_WIDE_BIT]; // RQ12
  end

  // Outputs come from flops, so the outside gates never see comparator glitches.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      strobe_n_r <= 1'b1;
      pin_nine_r <= 1'b1;
      pin_six_r  <= 1'b1;
      wide_one_r <= pcsd_pkg::RST_CYC[pcsd_pkg::CYC_ONE_WIDE_BIT];
      wide_two_r <= pcsd_pkg::RST_CYC[pcsd_pkg::CYC_TWO_WIDE_BIT];
    end else begin
      strobe_n_r <= strobe_n_nxt;
      pin_nine_r <= pin_nine_nxt;
      pin_six_r  <= pin_six_nxt;
      wide_one_r <= wide_one_nxt;
      wide_two_r <= wide_two_nxt;
    end
  end

  // Drive the ports from their flops.
  assign expansion_cycle_strobe_n_o = strobe_n_r;
  assign mem_addr_pin_nine_o        = pin_nine_r;
  assign mem_addr_pin_six_o         = pin_six_r;
  assign rom_wide_one_o             = wide_one_r;
  assign rom_wide_two_o             = wide_two_r;
  assign sd_o                       = rd_data_r;
  assign sd_oe_o                    = sd_oe_r;

  // ==========================================================================
  // Assertions.
  // A disabled write decode never selects channel one.
  no_write_sel_a: assert property ( // RQ6
    @(posedge core_clk_i) disable iff (reset_i)
    (cyc.is_wr && !cyc.is_rd && !one_ctrl_r[pcsd_pkg::CTRL_WR_EN_BIT]) |=> mem_addr_pin_nine_o
  ) else $error("channel one selected on a disabled write");

  // A disabled read decode never selects channel one.
  no_read_sel_a: assert property ( // RQ7
    @(posedge core_clk_i) disable iff (reset_i)
    (cyc.is_rd && !cyc.is_wr && !one_ctrl_r[pcsd_pkg::CTRL_RD_EN_BIT]) |=> mem_addr_pin_nine_o
  ) else $error("channel one selected on a disabled read");

  // Without command or latch strobe nothing is selected.
  idle_no_sel_a: assert property ( // RQ8
    @(posedge core_clk_i) disable iff (reset_i)
    (!cyc.cmd && !cyc.ale) |=> expansion_cycle_strobe_n_o
  ) else $error("select strobe active outside any cycle");

  // Channel one in I/O mode ignores every non-I/O cycle.
  kind_one_a: assert property ( // RQ9
    @(posedge core_clk_i) disable iff (reset_i)
    (!cyc.is_io && !cyc_type_r[pcsd_pkg::CYC_ONE_ROM_BIT]) |=> mem_addr_pin_nine_o
  ) else $error("channel one selected on a cycle of the wrong kind");

  // Channel two in I/O mode ignores every non-I/O cycle.
  kind_two_a: assert property ( // RQ10
    @(posedge core_clk_i) disable iff (reset_i)
    (!cyc.is_io && !cyc_type_r[pcsd_pkg::CYC_TWO_ROM_BIT]) |=> mem_addr_pin_six_o
  ) else $error("channel two selected on a cycle of the wrong kind");

  // Nonzero upper I/O bits block channel one when they must be zero.
  upper_zero_a: assert property ( // RQ14
    @(posedge core_clk_i) disable iff (reset_i)
    (upper_zero_lvl && !cyc_type_r[pcsd_pkg::CYC_ONE_ROM_BIT] && (addr_lvl[15:10] != 6'h00)) |=> mem_addr_pin_nine_o
  ) else $error("channel one selected with upper I/O bits set");

  // A data port access leaves no index behind.
  index_clear_a: assert property ( // RQ15
    @(posedge core_clk_i) disable iff (reset_i)
    ((wr_start || rd_start) && dat_port) |=> !idx_valid_r
  ) else $error("index survived a data port access");

  // The data bus is released once the read command ends.
  bus_release_a: assert property ( // RQ15
    @(posedge core_clk_i) disable iff (reset_i)
    (sd_oe_o && ior_n_lvl) |=> !sd_oe_o
  ) else $error("data bus still driven after the read ended");

  // Main scenarios: each select, and a register read.
  sel_one_c: cover property (@(posedge core_clk_i) disable iff (reset_i) !mem_addr_pin_nine_o);
  sel_two_c: cover property (@(posedge core_clk_i) disable iff (reset_i) !mem_addr_pin_six_o);
  reg_read_c: cover property (@(posedge core_clk_i) disable iff (reset_i) sd_oe_o);

endmodule

//--- verif/pcsd_peer.sv
/*
  Outside gates that turn the decoder's strobe and pins into two selects.
  Assumes the decoder outputs drive it directly and DMA raises aen_i.
*/
`timescale 1ns/1ns
module pcsd_peer (
  // Decoder side.
  input  wire logic strobe_n_i,
  input  wire logic aen_i,
  input  wire logic pin_nine_i,
  input  wire logic pin_six_i,
  // Selects seen by the peripheral.
  output logic      sel_one_n_o,
  output logic      sel_two_n_o
);
  // ==========================================================================
  // The strobe is qualified first, so DMA cycles can never select a device.
  logic qual_n;
  assign qual_n      = strobe_n_i | aen_i;
  assign sel_one_n_o = qual_n | pin_nine_i;
  assign sel_two_n_o = qual_n | pin_six_i;
endmodule

//--- verif/programmable_chip_select_decoder_bench.sv
/*
  Bench of the decoder: set-up through the index and data ports, then random I/O decodes.
  Assumes pcsd_pkg, pcsd_top and pcsd_peer.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("BAD %s %h %h", n, e, g); end end
module programmable_chip_select_decoder_bench;
  // ==========================================================================
  logic        core_clk_i = 1'b0;
  logic        reset_i    = 1'b1;
  logic [23:0] sa_i       = 24'h000000;
  logic        ior_n_i    = 1'b1;
  logic        iow_n_i    = 1'b1;
  logic [7:0]  sd_i       = 8'h00;
  logic        aen        = 1'b0;
  logic        s2, o;
  logic [5:0]  u;
  logic [7:0]  sd_o, b, c, q;
  logic        oe, strobe_n, pin9, pin6, wide1, wide2, sel1_n, sel2_n, l, g, w, s;
  logic [9:0]  a;
  int          err_count  = 0;
  int          compares   = 0;
  int          cyc        = 0;
  pcsd_top DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .sa_i(sa_i), .ior_n_i(ior_n_i), .iow_n_i(iow_n_i),
    .memr_n_i(1'b1), .memw_n_i(1'b1), .ale_i(1'b0), .aen_i(aen), .io_upper_zero_i(1'b1), .sd_i(sd_i),
    .sd_o(sd_o), .sd_oe_o(oe), .expansion_cycle_strobe_n_o(strobe_n), .mem_addr_pin_nine_o(pin9),
    .mem_addr_pin_six_o(pin6), .rom_wide_one_o(wide1), .rom_wide_two_o(wide2));
  pcsd_peer PEER (.strobe_n_i(strobe_n), .aen_i(aen), .pin_nine_i(pin9), .pin_six_i(pin6),
    .sel_one_n_o(sel1_n), .sel_two_n_o(sel2_n));
  // Expected hit of channel one: masked bits drop out of the compare.
  function automatic logic hit(logic [9:0] x, logic [7:0] bb, logic [7:0] cc, logic ll, logic gg, logic ww);
    hit = (((x ^ {cc[7], bb, ll}) & ~{5'h00, cc[3:0], gg}) == 10'h000) && (ww ? cc[6] : cc[5]);
  endfunction
  // Long command so the pin synchroniser has settled before sampling.
  task automatic bus(input logic [15:0] ad, input logic wr, input logic [7:0] d, output logic [7:0] r,
                     output logic sl);
    @(negedge core_clk_i);
    sa_i = {8'h00, ad};
    sd_i = d;
    iow_n_i = !wr;
    ior_n_i = wr;
    repeat (pcsd_pkg::SYNC_STAGES + 4) @(negedge core_clk_i);
    r = sd_o;
    sl = sel1_n;
    s2 = sel2_n;
    o = oe;
    iow_n_i = 1'b1;
    ior_n_i = 1'b1;
    repeat (pcsd_pkg::SYNC_STAGES + 4) @(negedge core_clk_i);
  endtask
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    bus(16'h0022, 1'b1, i, q, s);
    bus(16'h0024, 1'b1, d, q, s);
  endtask
  task automatic get(input logic [7:0] i, output logic [7:0] r);
    bus(16'h0022, 1'b1, i, q, s);
    bus(16'h0024, 1'b0, 8'h00, r, s);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  always #20 core_clk_i = ~core_clk_i;
  // A hang ends the run as a failure.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(5419));
    repeat (16) @(posedge core_clk_i);
    @(negedge core_clk_i) reset_i = 1'b0;
    get(pcsd_pkg::IDX_GRAN, q);
    `CHK("gran reset", pcsd_pkg::RST_GRAN, q)
    for (int i = 0; i < 12; i++) begin
      b = $urandom;
      c = $urandom;
      l = $urandom;
      g = $urandom;
      w = $urandom;
      put(pcsd_pkg::IDX_ONE_BASE, b);
      put(pcsd_pkg::IDX_ONE_CTRL, c);
      put(pcsd_pkg::IDX_GRAN, {2'b00, l, 3'b000, g, 1'b0});
      put(pcsd_pkg::IDX_CYC_TYPE, {1'b0, w, l, 5'h00});
      get(pcsd_pkg::IDX_ONE_CTRL, q);
      `CHK("ctrl readback", c, q)
      `CHK("data drive", 1'b1, o)
      `CHK("wide one", l, wide1)
      `CHK("wide two", w, wide2)
      a = {c[7], b, l} ^ (10'h001 << ($urandom % 11));
      if (a[9:1] == 9'h011 || a[9:1] == 9'h012) a[9] = 1'b1;
      u = ($urandom % 4 == 0) ? (6'h01 << ($urandom % 6)) : 6'h00;
      bus({u, a}, w, 8'h00, q, s);
      `CHK("select one", !(hit(a, b, c, l, g, w) && u == 6'h00), s)
      `CHK("select two", 1'b1, s2)
    end
    // A DMA cycle at the last decoded address, upper bits zero, must stay unselected.
    @(negedge core_clk_i) aen = 1'b1;
    bus({6'h00, a}, w, 8'h00, q, s);
    `CHK("dma blocked", 1'b1, s)
    final_report();
  end
endmodule
